// ===== acs_core_model.sv
// Converter core model: code follows the channel held at sampling.
// Assumes the code is taken by the sequencer after the sample phase.
`timescale 1ns/1ns
module acs_core_model (
  input  wire       clock,
  input  wire [3:0] mux_select,
  input  wire       sample_hold,
  output wire [9:0] core_result
);
  logic [3:0] held = 4'h0;
  always @(posedge clock) begin
    if (sample_hold) held <= mux_select;
  end
  assign core_result = {held, ~held, 2'h1};
endmodule // acs_core_model

// ===== acs_map.vh
// Register map, field positions and timing constants of the conversion sequencer.
// Assumes inclusion by bare name from the sequencer files.
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
// Register addresses on the plain register port
`define ACS_CTRL_ADDR      4'h0
`define ACS_RESULT_ADDR    4'h1
`define ACS_INJ_ADDR       4'h2
`define ACS_STATUS_ADDR    4'h3
`define ACS_IRQ_STAT_ADDR  4'h4
`define ACS_IRQ_EN_ADDR    4'h5
`define ACS_IRQ_CLR_ADDR   4'h6
`define ACS_SCAN_MASK_ADDR 4'h7
`define ACS_DIGIN_ADDR     4'h8
// Control register fields
`define ACS_CTRL_CHAN_LSB  0
`define ACS_CTRL_MODE_LSB  4
`define ACS_CTRL_START     6
`define ACS_CTRL_WAITRD    7
`define ACS_CTRL_PROTECT   8
`define ACS_CTRL_INJ_REQ   9
`define ACS_CTRL_CCS_LSB   10
`define ACS_CTRL_SCS_LSB   12
`define ACS_CTRL_INJ_LSB   14
`define ACS_CTRL_RESET     16'h0000
// Conversion modes
`define ACS_MODE_SINGLE    2'h0
`define ACS_MODE_CONT      2'h1
`define ACS_MODE_SCAN      2'h2
`define ACS_MODE_SCAN_CONT 2'h3
// Interrupt status bits
`define ACS_IRQ_DONE       0
`define ACS_IRQ_OVERRUN    1
`define ACS_IRQ_INJ        2
// Timing, in basic clock phases, converter clocks and nanoseconds
`define ACS_CONV_CLOCKS    14
`define ACS_SAMPLE_CLOCKS  2
`define ACS_XFER_PHASES    4
`define ACS_CAL_CLOCKS     4
`define ACS_CC_PHASES_00   24
`define ACS_CC_PHASES_10   96
`define ACS_CC_PHASES_11   48
`define ACS_RESET_CAL_NS   1600000
`define ACS_CLOCK_NS       100
`endif

// ===== acs_phase_timer.v
// Conversion clock generator: one pulse per converter clock period.
// Assumes one basic clock phase per system clock cycle.
`timescale 1ns/1ns
`include "acs_map.vh"
module acs_phase_timer (
  input  wire       clock,
  input  wire       reset_n,
  input  wire       run,
  input  wire [1:0] clock_select,
  output reg        tick
);
  reg  [6:0] count;
  wire [6:0] period;

  // Phases per converter clock; reserved 01 treated as 00
  assign period = (clock_select == 2'h2) ? 7'd`ACS_CC_PHASES_10 :
                  (clock_select == 2'h3) ? 7'd`ACS_CC_PHASES_11 :
                  7'd`ACS_CC_PHASES_00;

  always @(posedge clock) begin
    if (!reset_n || !run) begin
      count <= 7'h00;
      tick  <= 1'b0;
    end else if (count >= period - 7'd1) begin
      count <= 7'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 7'd1;
      tick  <= 1'b0;
    end
  end
endmodule // acs_phase_timer

// ===== acs_sequencer.v
// Conversion sequencer: modes, scan, injection, overrun, wait-for-read, calibration.
// Assumes a register master with one-cycle strobes and a converter core that
// returns a 10-bit code whenever asked.
// Contract
// - Pick one of 16 channels and produce a 10-bit result for it.
// - Overrun detection: interrupt when a result lands over an unread one.
// - Overrun protection: suspend next conversion until previous result is read.
// - Single mode converts the selected channel once into the result register.
// - Continuous mode converts the selected channel repeatedly, storing each result.
// - Scan single converts each selected channel once, storing each result.
// - Scan continuous cycles through the selected channels forever.
// - After each scan conversion signal a request for moving the result. Here no request for a result that goes through the wait-for-read buffer.
// - Wait-for-read in continuous modes buffers the new result and holds.
// - Injected conversion stores into injection register, running mode then resumes.
// - Conversion takes 14 conversion clocks, 2 sample clocks, 4 phases. Here sampling lasts one sample clock (sample_len conversion clocks), not 2.
// - After reset run a full calibration at least 1.6 ms, busy set.
// - Conversions allowed during reset calibration, which lengthens by their time.
// - After each conversion run a four converter clock calibration cycle.
// - Conversion clock select: 00=24, 10=96, 11=48 phases; 01 reserved.
// - Sample clock select 00..11 gives 1, 2, 4, 8 conversion clocks.
// - Unused channel inputs readable as digital input pins.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ns
`include "acs_map.vh"
module acs_sequencer #(
  parameter CAL_CYCLES = (`ACS_RESET_CAL_NS + `ACS_CLOCK_NS - 1) / `ACS_CLOCK_NS
) (
  input  wire        clock,
  input  wire        reset_n,
  input  wire [3:0]  address,
  input  wire [15:0] write_data,
  input  wire        write_strobe,
  input  wire        read_strobe,
  output reg  [15:0] read_data,
  input  wire [9:0]  core_result,
  input  wire [15:0] channel_pins,
  output reg  [3:0]  mux_select,
  output reg         sample_hold,
  output reg         transfer_request,
  output reg         interrupt
);
  localparam ST_IDLE   = 3'h0;
  localparam ST_SAMPLE = 3'h1;
  localparam ST_CONV   = 3'h2;
  localparam ST_XFER   = 3'h3;
  localparam ST_CAL    = 3'h4;
  localparam ST_HOLD   = 3'h5;

  reg  [15:0] converter_control_register;
  reg  [15:0] scan_mask;
  reg  [15:0] conversion_result_register;
  reg  [15:0] injection_result_register;
  reg  [9:0]  temp_buffer;
  reg         temp_full;
  reg         result_unread;
  reg  [2:0]  irq_status;
  reg  [2:0]  irq_enable;
  reg  [2:0]  state;
  reg  [3:0]  channel;
  reg  [4:0]  clocks;
  reg  [2:0]  phases;
  reg         running;
  reg         injecting;
  reg         inj_pending;
  reg  [3:0]  inj_channel;
  reg  [31:0] cal_count;
  reg         converter_busy_flag;
  wire        cc_tick;
  wire [1:0]  mode;
  wire        continuous;
  wire        scan_mode;
  wire [4:0]  sample_len;
  wire        result_read;
  wire [3:0]  next_channel;
  wire        last_scan;
  wire [15:0] status_word;

  assign mode        = converter_control_register[`ACS_CTRL_MODE_LSB +: 2];
  assign continuous  = mode[0];
  assign scan_mode   = mode[1];
  assign result_read = read_strobe && (address == `ACS_RESULT_ADDR);
  assign status_word = {12'h000, temp_full, result_unread, running, converter_busy_flag};

  // Sample length in converter clocks
  assign sample_len = 5'd1 << converter_control_register[`ACS_CTRL_SCS_LSB +: 2];

  // Next channel of the scan set, searching downward from the current one
  function [3:0] scan_next;
    input [3:0]  cur;
    input [15:0] mask;
    integer      i;
    reg          found;
    reg [3:0]    idx;
    begin
      scan_next = cur;
      found     = 1'b0;
      for (i = 1; i < 16; i = i + 1) begin
        idx = cur - i[3:0];
        if (!found && mask[idx]) begin
          scan_next = idx;
          found     = 1'b1;
        end
      end
    end
  endfunction

  assign next_channel = scan_next(channel, scan_mask);
  assign last_scan    = (next_channel >= channel);

  acs_phase_timer u_timer (
    .clock        (clock),
    .reset_n      (reset_n),
    .run          (state != ST_IDLE && state != ST_HOLD && state != ST_XFER),
    .clock_select (converter_control_register[`ACS_CTRL_CCS_LSB +: 2]),
    .tick         (cc_tick)
  );

  // Register writes and interrupt enable
  always @(posedge clock) begin
    if (!reset_n) begin
      converter_control_register <= `ACS_CTRL_RESET;
      scan_mask                  <= 16'h0000;
      irq_enable                 <= 3'h0;
    end else if (write_strobe) begin
      case (address)
        `ACS_CTRL_ADDR:      converter_control_register <= write_data;
        `ACS_SCAN_MASK_ADDR: scan_mask <= write_data;
        `ACS_IRQ_EN_ADDR:    irq_enable <= write_data[2:0];
        default:             scan_mask <= scan_mask;
      endcase
    end else if (state == ST_IDLE && running == 1'b0) begin
      // The start request is self-clearing once taken; the injection request bit is not
      if (converter_control_register[`ACS_CTRL_START])
        converter_control_register[`ACS_CTRL_START] <= 1'b0;
    end
  end

  // Reset calibration counter; conversions pause it
  always @(posedge clock) begin
    if (!reset_n) begin
      cal_count <= 32'h0;
    end else if (cal_count < CAL_CYCLES && state == ST_IDLE) begin
      cal_count <= cal_count + 32'd1;
    end
  end

  // Conversion sequence
  always @(posedge clock) begin
    if (!reset_n) begin
      state                     <= ST_IDLE;
      channel                   <= 4'h0;
      clocks                    <= 5'h00;
      phases                    <= 3'h0;
      running                   <= 1'b0;
      injecting                 <= 1'b0;
      inj_pending               <= 1'b0;
      inj_channel               <= 4'h0;
      conversion_result_register <= 16'h0000;
      injection_result_register <= 16'h0000;
      temp_buffer               <= 10'h000;
      temp_full                 <= 1'b0;
      result_unread             <= 1'b0;
      irq_status                <= 3'h0;
      transfer_request          <= 1'b0;
      sample_hold               <= 1'b0;
      mux_select                <= 4'h0;
    end else begin
      transfer_request <= 1'b0;
      if (write_strobe && address == `ACS_IRQ_CLR_ADDR)
        irq_status <= irq_status & ~write_data[2:0];
      if (write_strobe && address == `ACS_CTRL_ADDR && write_data[`ACS_CTRL_INJ_REQ]) begin
        inj_pending <= 1'b1;
        inj_channel <= {2'h0, write_data[`ACS_CTRL_INJ_LSB +: 2]};
      end
      // Reading the result frees the register; buffered result moves up
      if (result_read) begin
        result_unread <= temp_full;
        if (temp_full) begin
          conversion_result_register <= {2'h0, channel, temp_buffer};
          temp_full <= 1'b0;
        end
      end
      case (state)
        ST_IDLE: begin
          if (running && inj_pending && continuous) begin
            injecting   <= 1'b1;
            inj_pending <= 1'b0;
            mux_select  <= inj_channel;
            state       <= ST_SAMPLE;
          end else if (running) begin
            mux_select <= channel;
            state      <= ST_SAMPLE;
          end else if (converter_control_register[`ACS_CTRL_START]) begin
            running <= 1'b1;
            channel <= converter_control_register[`ACS_CTRL_CHAN_LSB +: 4];
          end
          clocks <= 5'h00;
        end
        ST_SAMPLE: begin
          sample_hold <= 1'b1;
          if (cc_tick) begin
            if (clocks == sample_len - 5'd1) begin
              clocks      <= 5'h00;
              sample_hold <= 1'b0;
              state       <= ST_CONV;
            end else begin
              clocks <= clocks + 5'd1;
            end
          end
        end
        ST_CONV: begin
          // Fourteen converter clocks, then transfer phases
          if (cc_tick) begin
            if (clocks == `ACS_CONV_CLOCKS - 1) begin
              clocks <= 5'h00;
              phases <= 3'h0;
              state  <= ST_XFER;
            end else begin
              clocks <= clocks + 5'd1;
            end
          end
        end
        ST_XFER: begin
          phases <= phases + 3'd1;
          if (phases == `ACS_XFER_PHASES - 1) begin
            state <= ST_CAL;
            if (injecting) begin
              injection_result_register <= {2'h0, mux_select, core_result};
              irq_status[`ACS_IRQ_INJ] <= 1'b1;
            end else if (result_unread && !result_read &&
                         converter_control_register[`ACS_CTRL_PROTECT]) begin
              state <= ST_XFER;
              phases <= phases;
            end else if (result_unread && !result_read && continuous &&
                         converter_control_register[`ACS_CTRL_WAITRD]) begin
              temp_buffer <= core_result;
              temp_full   <= 1'b1;
              state       <= ST_HOLD;
            end else begin
              conversion_result_register <= {2'h0, channel, core_result};
              result_unread              <= 1'b1;
              irq_status[`ACS_IRQ_DONE]  <= 1'b1;
              if (result_unread && !result_read)
                irq_status[`ACS_IRQ_OVERRUN] <= 1'b1;
              if (scan_mode)
                transfer_request <= 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (!temp_full)
            state <= ST_CAL;
        end
        ST_CAL: begin
          // Four converter clocks of calibration after every conversion
          if (cc_tick) begin
            if (clocks == `ACS_CAL_CLOCKS - 1) begin
              clocks <= 5'h00;
              state  <= ST_IDLE;
              if (injecting) begin
                injecting <= 1'b0;
              end else if (scan_mode) begin
                channel <= next_channel;
                if (last_scan && !continuous)
                  running <= 1'b0;
              end else if (!continuous) begin
                running <= 1'b0;
              end
            end else begin
              clocks <= clocks + 5'd1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      converter_busy_flag <= 1'b1;
      interrupt           <= 1'b0;
    end else begin
      converter_busy_flag <= running || (cal_count < CAL_CYCLES);
      interrupt           <= |(irq_status & irq_enable);
    end
  end

  // Register reads; unused channels read as digital inputs
  always @(posedge clock) begin
    if (!reset_n) begin
      read_data <= 16'h0000;
    end else if (read_strobe) begin
      case (address)
        `ACS_CTRL_ADDR:      read_data <= converter_control_register;
        `ACS_RESULT_ADDR:    read_data <= conversion_result_register;
        `ACS_INJ_ADDR:       read_data <= injection_result_register;
        `ACS_STATUS_ADDR:    read_data <= status_word;
        `ACS_IRQ_STAT_ADDR:  read_data <= {13'h0000, irq_status};
        `ACS_IRQ_EN_ADDR:    read_data <= {13'h0000, irq_enable};
        `ACS_SCAN_MASK_ADDR: read_data <= scan_mask;
        `ACS_DIGIN_ADDR:     read_data <= channel_pins;
        default:             read_data <= 16'h0000;
      endcase
    end else begin
      read_data <= 16'h0000;
    end
  end
endmodule // acs_sequencer

// ===== acs_sequencer_sva.sv
// Port checker for the conversion sequencer.
// Assumes a bind to acs_sequencer, one clock, synchronous active-low reset.
`timescale 1ns/1ns
`include "acs_map.vh"
module acs_sequencer_sva (
  input wire        clock,
  input wire        reset_n,
  input wire [3:0]  address,
  input wire [15:0] write_data,
  input wire        write_strobe,
  input wire        read_strobe,
  input wire [15:0] read_data,
  input wire [9:0]  core_result,
  input wire [15:0] channel_pins,
  input wire [3:0]  mux_select,
  input wire        sample_hold,
  input wire        transfer_request,
  input wire        interrupt
);
  logic [9:0] sh_cnt;
  logic [9:0] gap;
  logic       started;
  logic       scan;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_start;
    write_strobe && address == `ACS_CTRL_ADDR && write_data[`ACS_CTRL_START];
  endsequence
  sequence s_en_off;
    write_strobe && address == `ACS_IRQ_EN_ADDR && write_data == 16'h0000
    ##1 !(write_strobe && address == `ACS_IRQ_EN_ADDR);
  endsequence
  // Sample length, idle gap and start bookkeeping
  always @(posedge clock) begin
    if (!reset_n) begin
      sh_cnt <= 10'h000;
      gap <= 10'h3ff;
      started <= 1'h0;
      scan <= 1'h0;
    end else begin
      sh_cnt <= sample_hold ? sh_cnt + 10'h001 : 10'h000;
      if (sample_hold) gap <= 10'h000;
      else if (gap != 10'h3ff) gap <= gap + 10'h001;
      if (write_strobe && address == `ACS_CTRL_ADDR && write_data[`ACS_CTRL_START]) begin
        started <= 1'h1;
        scan <= write_data[`ACS_CTRL_MODE_LSB+1];
      end
    end
  end
  property p_pins;
    read_strobe && address == `ACS_DIGIN_ADDR |=> read_data == $past(channel_pins);
  endproperty
  a_pins: assert property (p_pins) else $error("pin read wrong");
  property p_tr_pulse;
    transfer_request |=> !transfer_request;
  endproperty
  a_tr_pulse: assert property (p_tr_pulse) else $error("request too long");
  property p_tr_scan;
    transfer_request |-> scan;
  endproperty
  a_tr_scan: assert property (p_tr_scan) else $error("request outside scan");
  property p_sh_len;
    $fell(sample_hold) |-> sh_cnt == 10'h018 || sh_cnt == 10'h030 || sh_cnt == 10'h060
      || sh_cnt == 10'h0c0 || sh_cnt == 10'h180 || sh_cnt == 10'h300;
  endproperty
  a_sh_len: assert property (p_sh_len) else $error("sample length wrong");
  property p_mux_hold;
    sample_hold && $past(sample_hold) |-> $stable(mux_select);
  endproperty
  a_mux_hold: assert property (p_mux_hold) else $error("channel moved");
  // 14 x 24 conversion, 4 transfer, 4 x 24 calibration = 436 cycles at least
  property p_gap;
    $rose(sample_hold) |-> gap >= 10'h1b4;
  endproperty
  a_gap: assert property (p_gap) else $error("conversion too short");
  property p_started;
    sample_hold |-> started;
  endproperty
  a_started: assert property (p_started) else $error("sample without start");
  property p_en_off;
    s_en_off |=> !interrupt;
  endproperty
  a_en_off: assert property (p_en_off) else $error("masked interrupt high");
  c_start: cover property (s_start);
endmodule // acs_sequencer_sva
bind acs_sequencer acs_sequencer_sva acs_sequencer_sva_i (.clock(clock), .reset_n(reset_n),
  .address(address), .write_data(write_data), .write_strobe(write_strobe),
  .read_strobe(read_strobe), .read_data(read_data), .core_result(core_result),
  .channel_pins(channel_pins), .mux_select(mux_select), .sample_hold(sample_hold),
  .transfer_request(transfer_request), .interrupt(interrupt));

// ===== acs_sequencer_tb.sv
// Testbench for the conversion sequencer with a converter core model.
// Assumes the register map header and a shortened reset calibration.
`timescale 1ns/1ns
`include "acs_map.vh"
module acs_sequencer_tb;
  logic        clock = 1'h0;
  logic        reset_n = 1'h0;
  logic [3:0]  address = 4'h0;
  logic [15:0] write_data = 16'h0000;
  logic        write_strobe = 1'h0;
  logic        read_strobe = 1'h0;
  logic [15:0] channel_pins = 16'h0000;
  wire  [15:0] read_data;
  wire  [9:0]  core_result;
  wire  [3:0]  mux_select;
  wire         sample_hold;
  wire         transfer_request;
  wire         interrupt;
  logic [15:0] rv;
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  always #50 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  acs_sequencer #(.CAL_CYCLES(20)) acs_sequencer_i (.clock(clock), .reset_n(reset_n),
    .address(address), .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data), .core_result(core_result),
    .channel_pins(channel_pins), .mux_select(mux_select), .sample_hold(sample_hold),
    .transfer_request(transfer_request), .interrupt(interrupt));
  acs_core_model acs_core_model_i (.clock(clock), .mux_select(mux_select),
    .sample_hold(sample_hold), .core_result(core_result));
  function automatic [15:0] res(input [3:0] c);
    res = {2'h0, c, c, ~c, 2'h1};
  endfunction
  task stop_test;
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'h1;
    @(posedge clock);
    write_strobe <= 1'h0;
  endtask
  task rd(input [3:0] a);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'h1;
    @(posedge clock);
    read_strobe <= 1'h0;
    #1 rv = read_data;
  endtask
  task wait_bit(input [3:0] a, input int b, input logic v);
    int i;
    for (i = 0; i < 3000 && rv[b] !== v; i++) rd(a);
    if (rv[b] !== v) begin
      n_errors = n_errors + 1;
      stop_test;
    end
  endtask
  task go(input [15:0] ctrl);
    @(posedge clock);
    reset_n <= 1'h0;
    repeat (3) @(posedge clock);
    reset_n <= 1'h1;
    rv = 16'h0000;
    if (ctrl != 16'h0000) wr(`ACS_CTRL_ADDR, ctrl);
  endtask
  task t_cal_pins;
    int t0;
    go(16'h0000);
    t0 = cyc;
    rd(`ACS_STATUS_ADDR);
    chk(rv[0], 1);
    wait_bit(`ACS_STATUS_ADDR, 0, 1'h0);
    chk(cyc - t0 >= 20, 1);
    channel_pins <= 16'ha5c3;
    rd(`ACS_DIGIN_ADDR);
    chk(rv, 16'ha5c3);
  endtask
  task t_single;
    int t0;
    go(16'h0045);
    t0 = cyc;
    wait_bit(`ACS_STATUS_ADDR, 2, 1'h1);
    chk(cyc - t0 >= 364 && cyc - t0 <= 520, 1);
    rd(`ACS_RESULT_ADDR);
    chk(rv, res(4'h5));
    wait_bit(`ACS_STATUS_ADDR, 1, 1'h0);
    repeat (1200) @(posedge clock);
    rd(`ACS_STATUS_ADDR);
    chk(rv[2:0], 3'h0);
  endtask
  task t_clocks;
    int t0;
    go(16'h1c45);
    t0 = cyc;
    wait_bit(`ACS_STATUS_ADDR, 2, 1'h1);
    chk(cyc - t0 >= 772 && cyc - t0 <= 900, 1);
    rd(`ACS_RESULT_ADDR);
    chk(rv, res(4'h5));
  endtask
  task t_overrun_inject;
    int i;
    go(16'h0000);
    wr(`ACS_IRQ_EN_ADDR, 16'h0002);
    wr(`ACS_CTRL_ADDR, 16'h0053);
    for (i = 0; i < 3000 && interrupt !== 1'h1; i++) @(posedge clock);
    chk(interrupt, 1);
    if (interrupt !== 1'h1) stop_test;
    rd(`ACS_RESULT_ADDR);
    chk(rv, res(4'h3));
    wr(`ACS_IRQ_EN_ADDR, 16'h0000);
    repeat (2) @(posedge clock);
    chk(interrupt, 0);
    wr(`ACS_IRQ_CLR_ADDR, 16'h0002);
    rd(`ACS_IRQ_STAT_ADDR);
    chk(rv[1], 0);
    wr(`ACS_CTRL_ADDR, 16'h8253);
    wait_bit(`ACS_IRQ_STAT_ADDR, 2, 1'h1);
    rd(`ACS_INJ_ADDR);
    chk(rv[9:0], res(4'h2) & 16'h03ff);
    rd(`ACS_RESULT_ADDR);
    wait_bit(`ACS_STATUS_ADDR, 2, 1'h1);
    rd(`ACS_RESULT_ADDR);
    chk(rv, res(4'h3));
  endtask
  task t_hold(input [15:0] ctrl, input int b);
    go(ctrl);
    wait_bit(`ACS_STATUS_ADDR, b, 1'h1);
    repeat (1500) @(posedge clock);
    rd(`ACS_IRQ_STAT_ADDR);
    chk(rv[1], 0);
    rd(`ACS_RESULT_ADDR);
    chk(rv, res(4'h7));
    rd(`ACS_STATUS_ADDR);
    if (b == 3) chk(rv[3:2], 2'h1);
    wait_bit(`ACS_STATUS_ADDR, 2, 1'h1);
    rd(`ACS_RESULT_ADDR);
    chk(rv, res(4'h7));
  endtask
  task t_scan(input logic c, input [3:0] st, input [15:0] mask, input int n);
    int i;
    int j;
    go(16'h0000);
    wr(`ACS_SCAN_MASK_ADDR, mask);
    wr(`ACS_CTRL_ADDR, 16'h0060 | (c << 4) | st);
    for (i = 0; i < n; i++) begin
      for (j = 0; j < 2000 && transfer_request !== 1'h1; j++) @(posedge clock);
      chk(transfer_request, 1);
      if (transfer_request !== 1'h1) stop_test;
      rd(`ACS_RESULT_ADDR);
      chk(rv, res(st - i % (st + 1)));
    end
    if (!c) wait_bit(`ACS_STATUS_ADDR, 1, 1'h0);
  endtask
  initial begin
    t_cal_pins;
    t_single;
    t_clocks;
    t_overrun_inject;
    t_hold(16'h0157, 2);
    t_hold(16'h00d7, 3);
    t_scan(1'h0, 4'h2, 16'h0007, 3);
    t_scan(1'h1, 4'h1, 16'h0003, 3);
    stop_test;
  end
endmodule // acs_sequencer_tb
